// File: acs_config_top.sv
`timescale 1ns/1ps
// Summary of operation
// RL1 - one-bit role: 0 end node, 1 coordinator, reset 0, host writable and readable
// RL2 - channel mask bit n enables channel 0x0B plus n
// RL3 - mask applies to every active and energy scan, whatever starts it
// RL4 - mask takes 0 to 0xFFFF, resets 0x1FFE; high-power forbids bits 0, 14, 15
// RL5 - dwell exponent takes 0 to 0x0F, resets to 4
// RL6 - scan time is channels times two to exponent times 15.36 ms
// RL7 - scanned channel count equals enabled bits; at most 16, or 13 high-power; a mask written before high-power is kept, so up to 16
// RL8 - end node uses exponent for its joining active scan; host sizes it
// RL9 - coordinator uses exponent for network and energy scans when reassignment enabled
// RL10 - option bit 0 clear: join only matching network number; set: any network
// RL11 - option bit 1 clear: join only configured channel; set: any channel
// RL12 - option bit 2 retries joins until success; beacon networks always join
// RL13 - option bit 3 polls the coordinator on every pin wake
// RL14 - join options take 0 to 0x0F, reset 0, bits 4 to 7 reserved
// RL15 - coordinator option bit 1 picks quietest channel by energy scan at start
// RL16 - out-of-range writes are refused, value kept, error reported
module acs_config_top import acs_pkg::*; #(
	parameter int UNIT_CYCLES = SCAN_UNIT_CYCLES
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [1:0] cmdSel,
	input wire logic [15:0] cmdData,
	output logic rspValid,
	output logic [15:0] rspData,
	output logic rspError,
	input wire logic highPowerPin,
	input wire logic pinWakePin,
	input wire logic hostActiveScanReq,
	input wire logic hostEnergyScanReq,
	input wire logic coordStartReq,
	input wire logic [2:0] coordStartOpts,
	input wire logic beaconNetwork,
	input wire logic associated,
	input wire logic candNetMatch,
	input wire logic candChanMatch,
	output logic roleCoord,
	output logic [15:0] channelMask,
	output logic [3:0] dwellExponent,
	output logic [7:0] joinOptions,
	output logic [4:0] enabledChannels,
	output logic [19:0] scanTimeUnits,
	output logic scanBusy,
	output logic scanEnergy,
	output logic [7:0] scanChannel,
	output logic scanChanStrobe,
	output logic scanDone,
	output logic joinAttempt,
	output logic joinAccept,
	output logic pollParent,
	output logic coordUseQuietest
);
	logic role_ff;
	logic [15:0] mask_ff;
	logic [3:0] dwell_ff;
	logic [7:0] join_ff;
	logic rspValid_ff;
	logic [15:0] rspData_ff;
	logic rspError_ff;
	logic [1:0] hpSync_ff;
	logic [2:0] wakeSync_ff;
	logic [4:0] chanCount_ff;
	logic [19:0] scanUnits_ff;
	logic scanStart_ff;
	logic scanMode_ff;
	logic joinWait_ff;
	logic joinAttempt_ff;
	logic joinAccept_ff;
	logic poll_ff;
	logic quiet_ff;
	logic walkBusy;
	logic walkDone;

	////////////////////////////////////////////////////////////////////////////////
	// command decode and range checks
	wire isWrite = cmdValid && cmdWrite;
	wire highPower = hpSync_ff[1];
	wire roleOk = (cmdData <= ROLE_MAX);
	wire maskOk = !(highPower && |(cmdData & MASK_HP_FORBID));
	wire dwellOk = (cmdData <= DWELL_MAX);
	wire joinOk = (cmdData <= JOIN_MAX);
	wire wrRole = isWrite && cmdSel == SEL_ROLE && roleOk;
	wire wrMask = isWrite && cmdSel == SEL_MASK && maskOk;
	wire wrDwell = isWrite && cmdSel == SEL_DWELL && dwellOk;
	wire wrJoin = isWrite && cmdSel == SEL_JOIN && joinOk;
	wire selOk = (cmdSel == SEL_ROLE) ? roleOk :
		(cmdSel == SEL_MASK) ? maskOk :
		(cmdSel == SEL_DWELL) ? dwellOk : joinOk;
	wire wrBad = isWrite && !selOk;
	wire [15:0] readMux = (cmdSel == SEL_ROLE) ? {15'h0000, role_ff} :
		(cmdSel == SEL_MASK) ? mask_ff :
		(cmdSel == SEL_DWELL) ? {12'h000, dwell_ff} : {8'h00, join_ff};

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			role_ff <= ROLE_RST;
			mask_ff <= MASK_RST;
			dwell_ff <= DWELL_RST;
			join_ff <= JOIN_RST;
		end else begin
			if (wrRole) role_ff <= cmdData[0]; // [RL1]
			if (wrMask) mask_ff <= cmdData; // [RL4]
			if (wrDwell) dwell_ff <= cmdData[3:0]; // [RL5]
			if (wrJoin) join_ff <= cmdData[7:0]; // [RL14]
		end
	end

	// one-cycle answer; refused writes keep the value and flag an error
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rspValid_ff <= 1'b0;
			rspData_ff <= 16'h0000;
			rspError_ff <= 1'b0;
		end else begin
			rspValid_ff <= cmdValid;
			rspData_ff <= cmdValid ? readMux : 16'h0000;
			rspError_ff <= wrBad; // [RL16]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			hpSync_ff <= 2'h0;
			wakeSync_ff <= 3'h0;
		end else begin
			hpSync_ff <= {hpSync_ff[0], highPowerPin};
			wakeSync_ff <= {wakeSync_ff[1:0], pinWakePin};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// enabled channel count and total scan time in 15.36 ms units
	logic [4:0] partial [0:16];
	assign partial[0] = 5'h00;
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_count
			assign partial[gi + 1] = partial[gi] + {4'h0, mask_ff[gi]}; // [RL7]
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			chanCount_ff <= 5'h00;
			scanUnits_ff <= 20'h0_0000;
		end else begin
			chanCount_ff <= partial[16]; // [RL7]
			scanUnits_ff <= {15'h0000, chanCount_ff} << dwell_ff; // [RL6]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// scan arbitration: host commands, coordinator start, end-node joining
	wire isEnd = (role_ff == ROLE_END_NODE);
	wire walkFree = !walkBusy && !scanStart_ff;
	wire coordScan = role_ff && coordStartReq &&
		(coordStartOpts[COORD_ANY_NET] || coordStartOpts[COORD_ANY_CHAN]);
	wire joinWanted = isEnd && !associated && (join_ff[JOIN_AUTO] || beaconNetwork);
	wire takeHost = walkFree && (hostActiveScanReq || hostEnergyScanReq);
	wire takeCoord = walkFree && !takeHost && coordScan;
	wire takeJoin = walkFree && !takeHost && !coordScan && joinWanted && !joinWait_ff;
	wire startMode = takeHost ? hostEnergyScanReq :
		coordStartOpts[COORD_ANY_CHAN];

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			scanStart_ff <= 1'b0;
			scanMode_ff <= 1'b0;
			joinWait_ff <= 1'b0;
			joinAttempt_ff <= 1'b0;
		end else begin
			scanStart_ff <= takeHost || takeCoord || takeJoin; // [RL3]
			scanMode_ff <= takeJoin ? 1'b0 : startMode; // [RL9]
			joinAttempt_ff <= takeJoin; // [RL8] [RL12]
			if (takeJoin) joinWait_ff <= 1'b1;
			else if (walkDone) joinWait_ff <= 1'b0; // [RL12]
		end
	end

	acs_scan_walker #(
		.UNIT_CYCLES(UNIT_CYCLES)
	) u_walker (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.startReq(scanStart_ff),
		.energyMode(scanMode_ff),
		.mask(mask_ff),
		.exponent(dwell_ff),
		.busy(walkBusy),
		.energy(scanEnergy),
		.channel(scanChannel),
		.chanStrobe(scanChanStrobe),
		.done(walkDone)
	);

	////////////////////////////////////////////////////////////////////////////////
	// join acceptance, pin-wake poll and coordinator channel choice
	wire netOk = join_ff[JOIN_ANY_NET] || candNetMatch;
	wire chanOk = join_ff[JOIN_ANY_CHAN] || candChanMatch;
	wire wakeRise = wakeSync_ff[1] && !wakeSync_ff[2];

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			joinAccept_ff <= 1'b0;
			poll_ff <= 1'b0;
			quiet_ff <= 1'b0;
		end else begin
			joinAccept_ff <= isEnd && netOk && chanOk; // [RL10] [RL11]
			poll_ff <= isEnd && join_ff[JOIN_POLL_WAKE] && wakeRise; // [RL13]
			quiet_ff <= role_ff && coordStartOpts[COORD_ANY_CHAN]; // [RL15]
		end
	end

	assign rspValid = rspValid_ff;
	assign rspData = rspData_ff;
	assign rspError = rspError_ff;
	assign roleCoord = role_ff;
	assign channelMask = mask_ff;
	assign dwellExponent = dwell_ff;
	assign joinOptions = join_ff;
	assign enabledChannels = chanCount_ff;
	assign scanTimeUnits = scanUnits_ff;
	assign scanBusy = walkBusy;
	assign scanDone = walkDone;
	assign joinAttempt = joinAttempt_ff;
	assign joinAccept = joinAccept_ff;
	assign pollParent = poll_ff;
	assign coordUseQuietest = quiet_ff;

	////////////////////////////////////////////////////////////////////////////////
	roleWrite_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL1]
		(isWrite && cmdSel == SEL_ROLE && cmdData <= ROLE_MAX) |=> roleCoord == $past(cmdData[0]))
		else $error("role write not stored");
	maskForbid_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL4]
		(isWrite && cmdSel == SEL_MASK && highPower && |(cmdData & MASK_HP_FORBID))
		|=> rspError && $stable(channelMask))
		else $error("forbidden mask bits accepted");
	dwellRange_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL5]
		(isWrite && cmdSel == SEL_DWELL && cmdData > DWELL_MAX) |=> rspError && $stable(dwellExponent))
		else $error("exponent out of range accepted");
	joinRange_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL14]
		joinOptions[7:4] == 4'h0)
		else $error("reserved join bits set");
	chanCount_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL7]
		$stable(channelMask) |=> enabledChannels == 5'($countones($past(channelMask))))
		else $error("channel count wrong");
	scanTime_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL6]
		($stable(enabledChannels) && $stable(dwellExponent))
		|=> scanTimeUnits == ({15'h0000, $past(enabledChannels)} << $past(dwellExponent)))
		else $error("scan time wrong");
	joinGate_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL10] [RL11]
		joinAccept |-> $past(isEnd && (join_ff[JOIN_ANY_NET] || candNetMatch)
		&& (join_ff[JOIN_ANY_CHAN] || candChanMatch)))
		else $error("join accepted against options");
	noAutoJoin_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL12]
		joinAttempt |-> $past(join_ff[JOIN_AUTO] || beaconNetwork) ##1 scanBusy)
		else $error("join attempt without permission");
	wakePoll_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL13]
		(wakeRise && isEnd && join_ff[JOIN_POLL_WAKE]) |=> pollParent ##1 !pollParent)
		else $error("pin wake poll missing");
	quietPick_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL15]
		(role_ff && coordStartOpts[COORD_ANY_CHAN]) |=> coordUseQuietest)
		else $error("quietest channel not chosen");
	rstValues_a: assert property (@(posedge clk_sys) sys_rst |=> // [RL1]
		roleCoord == ROLE_RST && channelMask == MASK_RST && dwellExponent == DWELL_RST
		&& joinOptions == JOIN_RST)
		else $error("reset values wrong");
	roleRefuse_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL16]
		(isWrite && cmdSel == SEL_ROLE && cmdData > ROLE_MAX) |=> rspError && $stable(roleCoord))
		else $error("role out of range accepted");
	joinRefuse_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL14]
		(isWrite && cmdSel == SEL_JOIN && cmdData > JOIN_MAX) |=> rspError && $stable(joinOptions))
		else $error("join options out of range accepted");
	maskWrite_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL4]
		(isWrite && cmdSel == SEL_MASK && !(highPower && |(cmdData & MASK_HP_FORBID)))
		|=> channelMask == $past(cmdData) && !rspError)
		else $error("mask write not stored");
	dwellWrite_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL5]
		(isWrite && cmdSel == SEL_DWELL && cmdData <= DWELL_MAX) |=> dwellExponent == $past(cmdData[3:0]))
		else $error("exponent write not stored");
	joinWrite_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL14]
		(isWrite && cmdSel == SEL_JOIN && cmdData <= JOIN_MAX) |=> joinOptions == $past(cmdData[7:0]))
		else $error("join options write not stored");
	rspPulse_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL16]
		rspValid == $past(cmdValid))
		else $error("answer not one cycle after command");
	readQuiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL16]
		(cmdValid && !cmdWrite) |=> rspValid && !rspError)
		else $error("read answered with error");
	pollGate_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL13]
		pollParent |-> $past(isEnd && join_ff[JOIN_POLL_WAKE]))
		else $error("poll without option");
	joinRole_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL8]
		joinAttempt |-> $past(isEnd && !associated))
		else $error("join attempt outside end-node role");
	joinActive_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL8]
		joinAttempt |=> scanBusy && !scanEnergy)
		else $error("join scan not an active scan");
	hostMode_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL3]
		takeHost |=> ##1 (scanBusy && scanEnergy == $past(hostEnergyScanReq, 2)))
		else $error("host scan kind wrong");
	coordMode_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL9]
		takeCoord |=> ##1 (scanBusy && scanEnergy == $past(coordStartOpts[COORD_ANY_CHAN], 2)))
		else $error("coordinator scan kind wrong");
endmodule : acs_config_top

// File: acs_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// host side of the configuration command port
module acs_host_model (
	input wire logic clk_sys,
	output logic cmdValid,
	output logic cmdWrite,
	output logic [1:0] cmdSel,
	output logic [15:0] cmdData,
	input wire logic rspValid,
	input wire logic [15:0] rspData,
	input wire logic rspError
);
	initial begin
		cmdValid = 1'b0;
		cmdWrite = 1'b0;
		cmdSel = 2'h0;
		cmdData = 16'h0000;
	end
	// one command; answer is {valid, error, data} from the cycle after acceptance
	task automatic command(input logic wr, input logic [1:0] sel, input logic [15:0] d,
		output logic [17:0] rsp);
		@(posedge clk_sys);
		cmdValid <= 1'b1;
		cmdWrite <= wr;
		cmdSel <= sel;
		cmdData <= d;
		@(posedge clk_sys);
		cmdValid <= 1'b0;
		cmdWrite <= ~wr;
		cmdSel <= ~sel;
		cmdData <= ~d;
		#1;
		rsp = {rspValid, rspError, rspData};
	endtask : command
endmodule : acs_host_model

// File: acs_pkg.sv
package acs_pkg;
	// register selectors on the configuration command port
	localparam logic [1:0] SEL_ROLE = 2'h0;
	localparam logic [1:0] SEL_MASK = 2'h1;
	localparam logic [1:0] SEL_DWELL = 2'h2;
	localparam logic [1:0] SEL_JOIN = 2'h3;
	// reset values
	localparam logic ROLE_RST = 1'h0;
	localparam logic [15:0] MASK_RST = 16'h1FFE;
	localparam logic [3:0] DWELL_RST = 4'h4;
	localparam logic [7:0] JOIN_RST = 8'h00;
	// permitted ranges
	localparam logic [15:0] ROLE_MAX = 16'h0001;
	localparam logic [15:0] DWELL_MAX = 16'h000F;
	localparam logic [15:0] JOIN_MAX = 16'h000F;
	localparam logic [15:0] MASK_HP_FORBID = 16'hC001;
	// role encoding
	localparam logic ROLE_END_NODE = 1'h0;
	localparam logic ROLE_COORD = 1'h1;
	// end-node join option bit positions
	localparam int JOIN_ANY_NET = 0;
	localparam int JOIN_ANY_CHAN = 1;
	localparam int JOIN_AUTO = 2;
	localparam int JOIN_POLL_WAKE = 3;
	// coordinator start option bit positions
	localparam int COORD_ANY_NET = 0;
	localparam int COORD_ANY_CHAN = 1;
	// channel numbering
	localparam logic [7:0] CHAN_BASE = 8'h0B;
	localparam logic [7:0] CHAN_LAST = 8'h1A;
	// scan timing: one dwell unit is 15.36 ms
	localparam longint SCAN_UNIT_NS = 64'h0000_0000_00EA_6000;
	localparam longint CLK_PERIOD_NS = 64'h0000_0000_0000_0019;
	localparam int SCAN_UNIT_CYCLES = int'((SCAN_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	typedef enum logic [1:0] {
		WALK_IDLE,
		WALK_SEEK,
		WALK_DWELL
	} acs_walk_e;
endpackage : acs_pkg

// File: acs_scan_walker.sv
`timescale 1ns/1ps
module acs_scan_walker import acs_pkg::*; #(
	parameter int UNIT_CYCLES = SCAN_UNIT_CYCLES
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic startReq,
	input wire logic energyMode,
	input wire logic [15:0] mask,
	input wire logic [3:0] exponent,
	output logic busy,
	output logic energy,
	output logic [7:0] channel,
	output logic chanStrobe,
	output logic done
);
	acs_walk_e state_ff;
	acs_walk_e nxt_state;
	logic [15:0] mask_ff;
	logic [3:0] exp_ff;
	logic [3:0] idx_ff;
	logic [31:0] unitCnt_ff;
	logic [15:0] repCnt_ff;
	logic energy_ff;
	logic strobe_ff;
	logic done_ff;
	logic busy_ff;
	logic [7:0] channel_ff;
	logic [15:0] repLimit;
	logic unitWrap;
	logic dwellEnd;
	logic lastIdx;
	logic idxOn;

	////////////////////////////////////////////////////////////////////////////////
	assign repLimit = (16'h0001 << exp_ff) - 16'h0001;
	assign unitWrap = (unitCnt_ff == 32'(UNIT_CYCLES - 1));
	assign dwellEnd = unitWrap && (repCnt_ff == repLimit);
	assign lastIdx = (idx_ff == 4'hF);
	assign idxOn = mask_ff[idx_ff];

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			WALK_IDLE: if (startReq) nxt_state = WALK_SEEK;
			WALK_SEEK: begin
				if (idxOn) nxt_state = WALK_DWELL;
				else if (lastIdx) nxt_state = WALK_IDLE;
			end
			WALK_DWELL: if (dwellEnd) nxt_state = lastIdx ? WALK_IDLE : WALK_SEEK;
		endcase
	end

	// mask and exponent latched at start apply to the whole scan [RL3]
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_ff <= WALK_IDLE;
			mask_ff <= 16'h0000;
			exp_ff <= 4'h0;
			idx_ff <= 4'h0;
			unitCnt_ff <= 32'h0000_0000;
			repCnt_ff <= 16'h0000;
			energy_ff <= 1'b0;
			strobe_ff <= 1'b0;
			done_ff <= 1'b0;
			busy_ff <= 1'b0;
			channel_ff <= CHAN_BASE; // [RL2]
		end else begin
			state_ff <= nxt_state;
			busy_ff <= (nxt_state != WALK_IDLE);
			strobe_ff <= (state_ff == WALK_SEEK) && idxOn;
			done_ff <= (state_ff != WALK_IDLE) && (nxt_state == WALK_IDLE);
			if (state_ff == WALK_IDLE && startReq) begin
				mask_ff <= mask; // [RL3]
				exp_ff <= exponent;
				energy_ff <= energyMode;
				idx_ff <= 4'h0;
				channel_ff <= CHAN_BASE; // [RL2]
			end
			if (state_ff == WALK_SEEK) begin
				unitCnt_ff <= 32'h0000_0000;
				repCnt_ff <= 16'h0000;
				if (!idxOn && !lastIdx) begin
					idx_ff <= idx_ff + 4'h1;
					channel_ff <= channel_ff + 8'h01; // [RL2]
				end
			end
			// each channel dwells 2^exponent units of 15.36 ms [RL6]
			if (state_ff == WALK_DWELL) begin
				unitCnt_ff <= unitWrap ? 32'h0000_0000 : unitCnt_ff + 32'h0000_0001; // [RL6]
				if (unitWrap) repCnt_ff <= repCnt_ff + 16'h0001;
				if (dwellEnd && !lastIdx) begin
					idx_ff <= idx_ff + 4'h1;
					channel_ff <= channel_ff + 8'h01; // [RL2]
				end
			end
		end
	end

	assign busy = busy_ff;
	assign energy = energy_ff;
	assign channel = channel_ff; // [RL2]
	assign chanStrobe = strobe_ff;
	assign done = done_ff;

	////////////////////////////////////////////////////////////////////////////////
	chanRange_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL2]
		busy |-> (channel >= CHAN_BASE && channel <= CHAN_LAST))
		else $error("scan channel out of range");
	emptyMask_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL7]
		(state_ff == WALK_IDLE && startReq && mask == 16'h0000) |-> ##[1:17] done)
		else $error("empty mask scan did not finish");
	dwellOnly_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RL3]
		chanStrobe |-> mask_ff[idx_ff])
		else $error("dwell on a disabled channel");
endmodule : acs_scan_walker

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
	import acs_pkg::*;
	localparam int UNITS = 4;
	logic clk_sys, sys_rst, cmdValid, cmdWrite, rspValid, rspError, highPowerPin, pinWakePin;
	logic hostActiveScanReq, hostEnergyScanReq, coordStartReq, beaconNetwork, associated;
	logic candNetMatch, candChanMatch, roleCoord, scanBusy, scanEnergy, scanChanStrobe;
	logic scanDone, joinAttempt, joinAccept, pollParent, coordUseQuietest;
	logic [1:0] cmdSel;
	logic [2:0] coordStartOpts;
	logic [3:0] dwellExponent;
	logic [4:0] enabledChannels;
	logic [7:0] joinOptions, scanChannel;
	logic [15:0] cmdData, rspData, channelMask;
	logic [19:0] scanTimeUnits;
	logic [17:0] rsp;
	logic [7:0] chanQ[$];
	int miscompares = 0;
	int num_checks = 0;
	int doneCnt = 0;
	int joinCnt = 0;
	int pollCnt = 0;
	int busyCnt = 0;
	acs_config_top #(.UNIT_CYCLES(UNITS)) uut (.clk_sys, .sys_rst, .cmdValid, .cmdWrite,
		.cmdSel, .cmdData, .rspValid, .rspData, .rspError, .highPowerPin, .pinWakePin,
		.hostActiveScanReq, .hostEnergyScanReq, .coordStartReq, .coordStartOpts,
		.beaconNetwork, .associated, .candNetMatch, .candChanMatch, .roleCoord, .channelMask,
		.dwellExponent, .joinOptions, .enabledChannels, .scanTimeUnits, .scanBusy, .scanEnergy,
		.scanChannel, .scanChanStrobe, .scanDone, .joinAttempt, .joinAccept, .pollParent,
		.coordUseQuietest);
	acs_host_model host (.clk_sys, .cmdValid, .cmdWrite, .cmdSel, .cmdData, .rspValid,
		.rspData, .rspError);
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// event counters seen at each edge
	always @(posedge clk_sys) begin
		doneCnt <= doneCnt + int'(scanDone === 1'b1);
		joinCnt <= joinCnt + int'(joinAttempt === 1'b1);
		pollCnt <= pollCnt + int'(pollParent === 1'b1);
		busyCnt <= busyCnt + int'(scanBusy === 1'b1);
		if (scanChanStrobe === 1'b1) begin
			chanQ.push_back(scanChannel);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done
	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cycles
	task automatic wr(input logic [1:0] sel, input logic [15:0] d, input logic err);
		host.command(1'b1, sel, d, rsp);
		check(rsp[17:16], {1'b1, err});
	endtask : wr
	task automatic rd(input logic [1:0] sel, input logic [15:0] exp);
		host.command(1'b0, sel, 16'h0000, rsp);
		check(rsp, {2'b10, exp});
	endtask : rd
	task automatic waitInc(ref int c, input int lim);
		int c0;
		c0 = c;
		for (int i = 0; i < lim && c == c0; i++) begin
			@(posedge clk_sys);
		end
		check(c != c0, 1);
	endtask : waitInc
	task automatic waitBusy();
		for (int i = 0; i < 20 && scanBusy !== 1'b1; i++) begin
			@(posedge clk_sys);
		end
	endtask : waitBusy
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(SEL_ROLE, 16'h0000);
		rd(SEL_MASK, 16'h1FFE);
		rd(SEL_DWELL, 16'h0004);
		rd(SEL_JOIN, 16'h0000);
		check(enabledChannels, 12);
		check(scanTimeUnits, 192);
	endtask : t_reset
	task automatic t_limits();
		wr(SEL_ROLE, 16'h0001, 1'b0);
		wr(SEL_ROLE, 16'h0002, 1'b1);
		rd(SEL_ROLE, 16'h0001);
		wr(SEL_DWELL, 16'h000F, 1'b0);
		wr(SEL_DWELL, 16'h0010, 1'b1);
		wr(SEL_JOIN, 16'h000F, 1'b0);
		wr(SEL_JOIN, 16'h0010, 1'b1);
		rd(SEL_JOIN, 16'h000F);
		check({roleCoord, dwellExponent, joinOptions}, 13'h1F0F);
		wr(SEL_MASK, 16'hFFFF, 1'b0);
		highPowerPin <= 1'b1;
		cycles(3);
		for (int i = 0; i < 16; i++) begin
			if (MASK_HP_FORBID[i]) begin
				wr(SEL_MASK, 16'h0001 << i, 1'b1);
			end
		end
		rd(SEL_MASK, 16'hFFFF);
		wr(SEL_MASK, 16'h3FFE, 1'b0);
		cycles(3);
		check(enabledChannels, 13);
		check(channelMask, 16'h3FFE);
		highPowerPin <= 1'b0;
		wr(SEL_ROLE, 16'h0000, 1'b0);
		wr(SEL_JOIN, 16'h0000, 1'b0);
	endtask : t_limits
	task automatic t_scan(input logic [15:0] m, input logic [3:0] e, input logic en,
		output int len);
		int b0;
		wr(SEL_MASK, m, 1'b0);
		wr(SEL_DWELL, {12'h000, e}, 1'b0);
		chanQ.delete();
		b0 = busyCnt;
		hostActiveScanReq <= ~en;
		hostEnergyScanReq <= en;
		waitBusy();
		hostActiveScanReq <= 1'b0;
		hostEnergyScanReq <= 1'b0;
		check(scanEnergy, en);
		waitInc(doneCnt, 300);
		cycles(1);
		len = busyCnt - b0;
	endtask : t_scan
	task automatic t_scans();
		int l0;
		int l2;
		t_scan(16'h8001, 4'h0, 1'b0, l0);
		check(chanQ.size(), 2);
		check({chanQ[0], chanQ[1]}, {CHAN_BASE, CHAN_LAST});
		check(scanTimeUnits, 2);
		t_scan(16'h0001, 4'h0, 1'b1, l0);
		t_scan(16'h0001, 4'h2, 1'b1, l2);
		check(l2 - l0, UNITS * 3);
		t_scan(16'h0000, 4'h0, 1'b0, l0);
		check(chanQ.size(), 0);
		check(scanTimeUnits, 0);
	endtask : t_scans
	task automatic t_join();
		associated <= 1'b0;
		cycles(40);
		check(joinCnt, 0);
		beaconNetwork <= 1'b1;
		waitInc(joinCnt, 20);
		beaconNetwork <= 1'b0;
		wr(SEL_JOIN, 16'h0004, 1'b0);
		waitInc(doneCnt, 300);
		waitInc(joinCnt, 20);
		associated <= 1'b1;
		waitInc(doneCnt, 300);
		wr(SEL_JOIN, 16'h0000, 1'b0);
		candNetMatch <= 1'b1;
		cycles(3);
		check(joinAccept, 1'b0);
		wr(SEL_JOIN, 16'h0002, 1'b0);
		cycles(2);
		check(joinAccept, 1'b1);
		wr(SEL_JOIN, 16'h0000, 1'b0);
		candNetMatch <= 1'b0;
		candChanMatch <= 1'b1;
		cycles(3);
		check(joinAccept, 1'b0);
		wr(SEL_JOIN, 16'h0001, 1'b0);
		cycles(2);
		check(joinAccept, 1'b1);
	endtask : t_join
	task automatic t_poll();
		int n;
		wr(SEL_JOIN, 16'h0008, 1'b0);
		pinWakePin <= 1'b1;
		waitInc(pollCnt, 6);
		pinWakePin <= 1'b0;
		wr(SEL_JOIN, 16'h0000, 1'b0);
		n = pollCnt;
		pinWakePin <= 1'b1;
		cycles(8);
		check(pollCnt, n);
		pinWakePin <= 1'b0;
	endtask : t_poll
	task automatic t_coord();
		wr(SEL_ROLE, 16'h0001, 1'b0);
		for (int k = 2; k > 0; k--) begin
			coordStartOpts <= 3'(k);
			coordStartReq <= 1'b1;
			waitBusy();
			coordStartReq <= 1'b0;
			check(scanEnergy, k == 2);
			waitInc(doneCnt, 300);
			check(coordUseQuietest, k == 2);
		end
	endtask : t_coord
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		{highPowerPin, pinWakePin, hostActiveScanReq, hostEnergyScanReq} = 4'h0;
		{coordStartReq, coordStartOpts, beaconNetwork} = 5'h00;
		{associated, candNetMatch, candChanMatch} = 3'b100;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_reset();
		t_limits();
		t_scans();
		t_join();
		t_poll();
		t_coord();
		test_done();
	end
	initial begin
		#(25 * 20000);
		miscompares++;
		test_done();
	end
endmodule : testbench
